// ---- src/rcw_params.svh ----
// Purpose: named constants of the reset cause and watchdog unit
// Assumes: 100 MHz core clock, 128 kHz watchdog oscillator on a pin
// Notes:   definitions only
`ifndef RCW_PARAMS_SVH
`define RCW_PARAMS_SVH

`define RCW_CLK_PERIOD_NS     10
`define RCW_EXT_MIN_PULSE_NS  2500
`define RCW_DROP_MIN_PULSE_NS 100
`define RCW_EXT_MIN_CYC  ((`RCW_EXT_MIN_PULSE_NS + `RCW_CLK_PERIOD_NS - 1) / `RCW_CLK_PERIOD_NS)
`define RCW_DROP_MIN_CYC ((`RCW_DROP_MIN_PULSE_NS + `RCW_CLK_PERIOD_NS - 1) / `RCW_CLK_PERIOD_NS)

`define RCW_ADDR_CAUSE   12'h000
`define RCW_ADDR_DOG     12'h004

`define RCW_BIT_DOG_FLAG    7
`define RCW_BIT_DOG_IRQ_EN  6
`define RCW_BIT_DOG_P3      5
`define RCW_BIT_DOG_UNLOCK  4
`define RCW_BIT_DOG_RST_EN  3
`define RCW_BIT_DOG_P2      2
`define RCW_BIT_DOG_P0      0
`define RCW_BIT_CAUSE_DOG   3
`define RCW_BIT_CAUSE_DROP  2
`define RCW_BIT_CAUSE_PIN   1
`define RCW_BIT_CAUSE_POWER 0

`define RCW_UNLOCK_CYC      3'h4
`define RCW_PERIOD_MAX      4'h9
`define RCW_DOG_BASE_CYC    2048
`define RCW_LEVEL_OFF       3'h7
`define RCW_LEVEL_LOW       3'h6
`define RCW_LEVEL_MID       3'h5
`define RCW_LEVEL_HIGH      3'h4

`endif

// ---- src/rcw_pkg.sv ----
// Purpose: shared types of the reset cause and watchdog unit
// Assumes: nothing
// Notes:   constants live in rcw_params.svh
package rcw_pkg;

  // watchdog control and status fields
  typedef struct packed {
    logic       irq_flag;
    logic       irq_en;
    logic       rst_en;
    logic [3:0] period;
  } rcw_dog_ctrl_type;

  // sticky reset cause flags
  typedef struct packed {
    logic dog;
    logic drop;
    logic pin;
    logic power;
  } rcw_cause_type;

  // reset sequencer states
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_DELAY,
    ST_RUN
  } rcw_seq_type;

endpackage

// ---- src/rcw_top.sv ----
// Purpose: reset source merging, start-up delay, cause flags and watchdog
// Assumes: apb slave, zero wait state; analog detectors and fuses arrive as pins
// Notes:   all pin inputs are synchronised before use
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "rcw_params.svh"

module rcw_top #(
  parameter int unsigned DOG_BASE_CYCLES = `RCW_DOG_BASE_CYC  // oscillator cycles at period code 0
) (
  input  wire logic        pclk,                  // core clock, 100 MHz
  input  wire logic        presetn,               // async reset, active low
  input  wire logic        psel,                  // apb select
  input  wire logic        penable,               // apb access phase
  input  wire logic        pwrite,                // apb direction
  input  wire logic [11:0] paddr,                 // apb byte address
  input  wire logic [31:0] pwdata,                // apb write data
  input  wire logic [3:0]  pstrb,                 // apb byte strobes
  output logic      [31:0] prdata,                // apb read data
  output logic             pready,                // apb ready
  output logic             pslverr,               // apb error on unmapped
  input  wire logic        power_ok_n,            // power detector, low = supply below level
  input  wire logic        ext_reset_pin_n,       // external reset pin, active low
  input  wire logic        supply_drop_low,       // drop detector, high = below trigger
  input  wire logic        dog_osc,               // 128 kHz watchdog oscillator
  input  wire logic        ext_pin_reset_disable_fuse, // programmed = pin ignored
  input  wire logic        dog_always_on_fuse,    // programmed = reset-only dog
  input  wire logic [2:0]  supply_drop_level_fuse,// trigger level code
  input  wire logic [23:0] startup_delay_period,  // start-up delay in core cycles
  input  wire logic        dog_restart,           // restart instruction, one-cycle pulse
  input  wire logic        dog_vector_taken,      // dog vector executing, one-cycle pulse
  output logic             core_reset_n,          // internal reset to the core, active low
  output logic             dog_irq,               // watchdog interrupt request, wakes sleep
  output logic             supply_drop_enable,    // drop detector and reference on
  output logic      [1:0]  supply_drop_level_sel  // trigger level to the detector
);

  localparam int unsigned SYNC_W = 9;
  localparam logic [8:0]  EXT_MIN  = 9'(`RCW_EXT_MIN_CYC);
  localparam logic [8:0]  DROP_MIN = 9'(`RCW_DROP_MIN_CYC);
  localparam logic [20:0] DOG_BASE = 21'(DOG_BASE_CYCLES);

  // two-flop synchronisers for every pin input
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;

  assign pin_raw = {supply_drop_level_fuse, dog_always_on_fuse, ext_pin_reset_disable_fuse,
                    dog_osc, supply_drop_low, ext_reset_pin_n, power_ok_n};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      // first stage feeds only the second
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic       power_low;
  logic       pin_low;
  logic       drop_raw;
  logic       osc_s;
  logic       pin_dis;
  logic       always_on;
  logic [2:0] level_code;

  assign power_low  = ~sync2_reg[0];
  assign pin_low    = ~sync2_reg[1];
  assign drop_raw   = sync2_reg[2];
  assign osc_s      = sync2_reg[3];
  assign pin_dis    = sync2_reg[4];
  assign always_on  = sync2_reg[5];
  assign level_code = sync2_reg[8:6];

  // level fuse decode; reserved codes leave detection off
  logic       drop_en;
  logic [1:0] drop_sel;
  always_comb begin
    drop_en  = 1'b1;
    drop_sel = 2'h0;
    unique case (level_code)
      `RCW_LEVEL_LOW:  drop_sel = 2'h1;
      `RCW_LEVEL_MID:  drop_sel = 2'h2;
      `RCW_LEVEL_HIGH: drop_sel = 2'h3;
      default:         drop_en  = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_drop_enable    <= 1'b0;
      supply_drop_level_sel <= 2'h0;
    end else begin
      supply_drop_enable    <= drop_en;
      supply_drop_level_sel <= drop_sel;
    end
  end

  // pulse-width filter on the reset pin; short glitches never reach the core
  logic [8:0] pin_cnt_reg;
  logic       pin_act;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cnt_reg <= 9'h000;
    end else if (!pin_low || pin_dis) begin
      pin_cnt_reg <= 9'h000;
    end else if (pin_cnt_reg != EXT_MIN) begin
      pin_cnt_reg <= pin_cnt_reg + 9'h001;
    end
  end
  assign pin_act = (pin_cnt_reg == EXT_MIN);

  // drop filter; release is immediate so the delay starts at once
  logic [8:0] drop_cnt_reg;
  logic       drop_act;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_cnt_reg <= 9'h000;
    end else if (!drop_raw || !drop_en) begin
      drop_cnt_reg <= 9'h000;
    end else if (drop_cnt_reg != DROP_MIN) begin
      drop_cnt_reg <= drop_cnt_reg + 9'h001;
    end
  end
  assign drop_act = (drop_cnt_reg == DROP_MIN);

  // watchdog reset pulse, exactly one core cycle
  logic dog_fire;
  logic dog_pulse_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_pulse_reg <= 1'b0;
    end else begin
      dog_pulse_reg <= dog_fire & ~dog_pulse_reg;
    end
  end

  logic any_src;
  assign any_src = power_low | pin_act | drop_act | dog_pulse_reg;

  // reset sequencer: hold while any source, then stretch
  rcw_pkg::rcw_seq_type seq_reg;
  logic [23:0]          delay_cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg       <= rcw_pkg::ST_HOLD;
      delay_cnt_reg <= 24'h000000;
    end else if (any_src) begin
      seq_reg       <= rcw_pkg::ST_HOLD;
      delay_cnt_reg <= 24'h000000;
    end else begin
      unique case (seq_reg)
        rcw_pkg::ST_HOLD: begin
          seq_reg       <= rcw_pkg::ST_DELAY;
          delay_cnt_reg <= 24'h000000;
        end
        rcw_pkg::ST_DELAY: begin
          if (delay_cnt_reg >= startup_delay_period) begin
            seq_reg <= rcw_pkg::ST_RUN;
          end else begin
            delay_cnt_reg <= delay_cnt_reg + 24'h000001;
          end
        end
        rcw_pkg::ST_RUN: begin
          seq_reg <= rcw_pkg::ST_RUN;
        end
      endcase
    end
  end

  // registered so the core reset never glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= ~any_src & (seq_reg == rcw_pkg::ST_RUN);
    end
  end

  // apb decode
  logic acc_wr;
  logic setup;
  logic hit_cause;
  logic hit_dog;
  assign setup     = psel & ~penable;
  assign hit_cause = (paddr == `RCW_ADDR_CAUSE);
  assign hit_dog   = (paddr == `RCW_ADDR_DOG);
  assign acc_wr    = psel & penable & pready & pwrite & pstrb[0] & ~pslverr;

  // cause flags; a set in the same cycle beats the software clear
  rcw_pkg::rcw_cause_type cause_reg;
  logic                   cause_wr;
  assign cause_wr = acc_wr & hit_cause;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= '0;
    end else if (power_low) begin
      cause_reg.power <= 1'b1;
      cause_reg.pin   <= 1'b0;
      cause_reg.drop  <= 1'b0;
      cause_reg.dog   <= 1'b0;
    end else begin
      if (cause_wr && !pwdata[`RCW_BIT_CAUSE_POWER]) begin
        cause_reg.power <= 1'b0;
      end
      if (pin_act) begin
        cause_reg.pin <= 1'b1;
      end else if (cause_wr && !pwdata[`RCW_BIT_CAUSE_PIN]) begin
        cause_reg.pin <= 1'b0;
      end
      if (drop_act) begin
        cause_reg.drop <= 1'b1;
      end else if (cause_wr && !pwdata[`RCW_BIT_CAUSE_DROP]) begin
        cause_reg.drop <= 1'b0;
      end
      if (dog_pulse_reg) begin
        cause_reg.dog <= 1'b1;
      end else if (cause_wr && !pwdata[`RCW_BIT_CAUSE_DOG]) begin
        cause_reg.dog <= 1'b0;
      end
    end
  end

  // change-unlock window counter
  logic [2:0] unlock_cnt_reg;
  logic       unlocked;
  logic       dog_wr;
  logic       unlock_wr;
  assign dog_wr    = acc_wr & hit_dog;
  assign unlock_wr = dog_wr & pwdata[`RCW_BIT_DOG_UNLOCK] & pwdata[`RCW_BIT_DOG_RST_EN];
  assign unlocked  = (unlock_cnt_reg != 3'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_cnt_reg <= 3'h0;
    end else if (unlock_wr) begin
      unlock_cnt_reg <= `RCW_UNLOCK_CYC;
    end else if (unlocked) begin
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
    end
  end

  // effective mode bits as seen by logic and software
  rcw_pkg::rcw_dog_ctrl_type dog_reg;
  logic                      rst_en_eff;
  logic                      irq_en_eff;
  logic [3:0]                wr_period;
  assign rst_en_eff = dog_reg.rst_en | cause_reg.dog | always_on;
  assign irq_en_eff = dog_reg.irq_en & ~always_on;
  assign wr_period  = {pwdata[`RCW_BIT_DOG_P3], pwdata[`RCW_BIT_DOG_P2:`RCW_BIT_DOG_P0]};

  // watchdog counter on synchronised oscillator edges
  logic        osc_d_reg;
  logic        osc_tick;
  logic [20:0] dog_cnt_reg;
  logic [20:0] dog_limit;
  logic        dog_running;
  logic        dog_expire;
  assign osc_tick    = osc_s & ~osc_d_reg;
  assign dog_limit   = DOG_BASE << dog_reg.period;
  assign dog_running = rst_en_eff | irq_en_eff;
  assign dog_expire  = osc_tick & dog_running & (dog_cnt_reg + 21'h000001 >= dog_limit);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_d_reg   <= 1'b0;
      dog_cnt_reg <= 21'h000000;
    end else begin
      osc_d_reg <= osc_s;
      if (dog_restart || !dog_running || any_src || dog_expire) begin
        dog_cnt_reg <= 21'h000000;
      end else if (osc_tick) begin
        dog_cnt_reg <= dog_cnt_reg + 21'h000001;
      end
    end
  end

  // time-out action: interrupt first when enabled and not pending, else reset
  logic irq_set;
  assign irq_set  = dog_expire & irq_en_eff & ~dog_reg.irq_flag;
  assign dog_fire = dog_expire & rst_en_eff & ~irq_set;

  // control register; cleared while a reset source is active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_reg <= '0;
    end else if (any_src) begin
      dog_reg <= '0;
    end else begin
      if (irq_set) begin
        dog_reg.irq_flag <= 1'b1;
      end else if (dog_vector_taken || (dog_wr && pwdata[`RCW_BIT_DOG_FLAG])) begin
        dog_reg.irq_flag <= 1'b0;
      end
      if (dog_vector_taken && rst_en_eff && !irq_set) begin
        dog_reg.irq_en <= 1'b0;
      end else if (dog_wr) begin
        dog_reg.irq_en <= pwdata[`RCW_BIT_DOG_IRQ_EN];
      end
      if (dog_wr && unlocked && !pwdata[`RCW_BIT_DOG_UNLOCK]) begin
        dog_reg.rst_en <= pwdata[`RCW_BIT_DOG_RST_EN];
        if (wr_period <= `RCW_PERIOD_MAX) begin
          dog_reg.period <= wr_period;
        end
      end else if (dog_wr && pwdata[`RCW_BIT_DOG_RST_EN]) begin
        dog_reg.rst_en <= 1'b1;                          // setting is never locked
      end
    end
  end

  // interrupt request held while flag and enable stand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_irq <= 1'b0;
    end else begin
      dog_irq <= dog_reg.irq_flag & irq_en_eff;
    end
  end

  // apb answer built in setup, shown in the single access cycle
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    if (hit_cause) begin
      rd_word[`RCW_BIT_CAUSE_DOG:`RCW_BIT_CAUSE_POWER] = cause_reg;
    end else if (hit_dog) begin
      rd_word[`RCW_BIT_DOG_FLAG]   = dog_reg.irq_flag;
      rd_word[`RCW_BIT_DOG_IRQ_EN] = irq_en_eff;
      rd_word[`RCW_BIT_DOG_P3]     = dog_reg.period[3];
      rd_word[`RCW_BIT_DOG_UNLOCK] = unlocked;
      rd_word[`RCW_BIT_DOG_RST_EN] = rst_en_eff;
      rd_word[`RCW_BIT_DOG_P2:`RCW_BIT_DOG_P0] = dog_reg.period[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~(hit_cause | hit_dog);
      prdata  <= (setup && !pwrite) ? rd_word : 32'h00000000;
    end
  end

endmodule // rcw_top

// ---- test/rcw_top_sva.sv ----
// Purpose: concurrent checks on the rcw_top ports
// Assumes: bound from the bench top file
// Notes:   filter lengths tracked by helper counters
`timescale 1ns/1ps

module rcw_top_sva (
  input wire logic        pclk,                       // core clock
  input wire logic        presetn,                    // async reset
  input wire logic        psel,                       // apb select
  input wire logic        penable,                    // apb access
  input wire logic        pwrite,                     // apb direction
  input wire logic [11:0] paddr,                      // apb address
  input wire logic [31:0] prdata,                     // apb read data
  input wire logic        pready,                     // apb ready
  input wire logic        pslverr,                    // apb error
  input wire logic        power_ok_n,                 // power detector
  input wire logic        ext_reset_pin_n,            // reset pin
  input wire logic        ext_pin_reset_disable_fuse, // pin ignored
  input wire logic        supply_drop_low,            // drop detector
  input wire logic [2:0]  supply_drop_level_fuse,     // level code
  input wire logic [23:0] startup_delay_period,       // delay length
  input wire logic        dog_vector_taken,           // vector pulse
  input wire logic        core_reset_n,               // core reset
  input wire logic        dog_irq,                    // dog interrupt
  input wire logic        supply_drop_enable,         // detector on
  input wire logic [1:0]  supply_drop_level_sel       // level select
);
  int pin_cnt;
  int drop_cnt;
  int quiet_cnt;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // length of the present pin low, only while the pin counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_cnt <= 0;
    else if (ext_reset_pin_n || ext_pin_reset_disable_fuse) pin_cnt <= 0;
    else if (pin_cnt < 1000) pin_cnt <= pin_cnt + 1;
  end

  // length of the present enabled drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) drop_cnt <= 0;
    else if (!(supply_drop_low && supply_drop_enable)) drop_cnt <= 0;
    else if (drop_cnt < 1000) drop_cnt <= drop_cnt + 1;
  end

  // cycles since the last power low or sustained pin or drop source; pin and drop glitches do not restart it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_cnt <= 0;
    else if (!power_ok_n || pin_cnt > 250 || drop_cnt > 10) quiet_cnt <= 0;
    else if (quiet_cnt < 100000) quiet_cnt <= quiet_cnt + 1;
  end

  sequence s_setup;
    psel && !penable;
  endsequence

  a_power_low_reset: assert property (!power_ok_n |-> ##[0:3] !core_reset_n)
    else $error("power low without core reset");
  a_pin_long_reset: assert property (pin_cnt == 260 |-> !core_reset_n)
    else $error("long pin low without core reset");
  a_drop_reset: assert property (drop_cnt == 16 |-> !core_reset_n)
    else $error("drop without core reset");
  a_release_delay: assert property ($rose(core_reset_n) |-> quiet_cnt > startup_delay_period)
    else $error("core reset released before start-up delay");
  a_drop_off_code: assert property ((supply_drop_level_fuse == 3'h7)[*6]
    |-> !supply_drop_enable && supply_drop_level_sel == 2'h0)
    else $error("drop detector on with level code off");
  a_drop_level_code: assert property ((supply_drop_level_fuse inside {3'h4, 3'h5, 3'h6}
    && $stable(supply_drop_level_fuse))[*6] |-> supply_drop_enable
    && supply_drop_level_sel == 2'(3'h7 - supply_drop_level_fuse))
    else $error("wrong drop level select");
  a_vector_clears: assert property (dog_irq && dog_vector_taken |-> ##[1:3] !dog_irq)
    else $error("vector did not clear dog interrupt");
  a_ready_next: assert property (s_setup |=> pready ##1 !pready)
    else $error("apb ready not one cycle after setup");
  a_unmapped_err: assert property (s_setup ##0 !(paddr inside {12'h000, 12'h004}) |=> pslverr)
    else $error("unmapped access without error");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule // rcw_top_sva

// ---- test/rcw_top_bench.sv ----
// Purpose: self-checking bench of rcw_top
// Assumes: fast dog oscillator and base count 8 keep the run short
// Notes:   cause flags modelled in cm
`timescale 1ns/1ps

module rcw_top_bench;
  logic        pclk = 1'b0;
  logic        dog_osc = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        power_ok_n, ext_reset_pin_n, supply_drop_low, ext_pin_reset_disable_fuse;
  logic        dog_always_on_fuse, dog_restart, dog_vector_taken, core_reset_n, dog_irq;
  logic        supply_drop_enable;
  logic [2:0]  supply_drop_level_fuse;
  logic [1:0]  supply_drop_level_sel;
  logic [23:0] startup_delay_period;
  int          failures, checks, cyc, cm;
  integer      seed;

  rcw_top #(.DOG_BASE_CYCLES(8)) u_rcw_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .power_ok_n, .ext_reset_pin_n, .supply_drop_low,
    .dog_osc, .ext_pin_reset_disable_fuse, .dog_always_on_fuse, .supply_drop_level_fuse,
    .startup_delay_period, .dog_restart, .dog_vector_taken, .core_reset_n, .dog_irq,
    .supply_drop_enable, .supply_drop_level_sel);

  // clocks; dog oscillator sped up and out of phase with pclk
  always #5 pclk = ~pclk;
  always #103 dog_osc = ~dog_osc;

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask

  // bounded wait; s picks dog_irq over core_reset_n
  task automatic waitv(input logic s, input logic v, input int lim);
    int k;
    k = 0;
    while ((s ? dog_irq : core_reset_n) !== v && k < lim) begin
      @(posedge pclk);
      k++;
    end
    chk({31'h0, s ? dog_irq : core_reset_n}, {31'h0, v});
  endtask

  // k picks drop detector over reset pin
  task automatic src(input logic k, input int len);
    if (k) supply_drop_low <= 1'b1;
    else ext_reset_pin_n <= 1'b0;
    repeat (len) @(posedge pclk);
    supply_drop_low <= 1'b0;
    ext_reset_pin_n <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic pulse(input logic s);
    if (s) dog_vector_taken <= 1'b1;
    else dog_restart <= 1'b1;
    @(posedge pclk);
    dog_vector_taken <= 1'b0;
    dog_restart <= 1'b0;
  endtask

  // after a dog reset: restart first, the forced enable keeps it counting
  task automatic dog_off();
    pulse(1'b0);
    rd(12'h000, 32'(cm));
    rd(12'h004, 32'h08);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h18);
    apb(1'b1, 12'h004, 32'h00);
    cm = 0;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, power_ok_n, dog_restart, dog_vector_taken} = '0;
    {ext_pin_reset_disable_fuse, dog_always_on_fuse, supply_drop_low} = '0;
    {paddr, pwdata} = '0;
    pstrb = 4'hf;
    ext_reset_pin_n = 1'b1;
    supply_drop_level_fuse = 3'h7;
    startup_delay_period = 24'h14;
    seed = 32'haddb;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    power_ok_n <= 1'b1;
    cm = 1;
    waitv(1'b0, 1'b1, 300);
    rd(12'h000, 32'(cm));
    apb(1'b1, 12'h000, 32'h0);
    cm = 0;
    rd(12'h000, 32'(cm));
    src(1'b0, 20 + ($random(seed) & 127));
    rd(12'h000, 32'(cm));
    src(1'b0, 300);
    cm = cm | 2;
    waitv(1'b0, 1'b1, 400);
    rd(12'h000, 32'(cm));
    apb(1'b1, 12'h000, 32'h0);
    cm = 0;
    ext_pin_reset_disable_fuse <= 1'b1;
    src(1'b0, 300);
    ext_pin_reset_disable_fuse <= 1'b0;
    rd(12'h000, 32'(cm));
    $display("test pin and power done");
    for (int k = 0; k < 8; k++) begin
      supply_drop_level_fuse <= 3'(k);
      repeat (8) @(posedge pclk);
      chk({31'h0, supply_drop_enable}, 32'(k >= 4 && k <= 6));
      chk({30'h0, supply_drop_level_sel}, 32'((k >= 4 && k <= 6) ? 7 - k : 0));
    end
    supply_drop_level_fuse <= 3'h6;
    src(1'b1, 1 + ($random(seed) & 7));
    rd(12'h000, 32'(cm));
    src(1'b1, 40);
    cm = cm | 4;
    waitv(1'b0, 1'b1, 300);
    rd(12'h000, 32'(cm));
    apb(1'b1, 12'h000, 32'h0);
    cm = 0;
    supply_drop_level_fuse <= 3'h7;
    $display("test drop done");
    apb(1'b1, 12'h004, 32'h18);
    apb(1'b1, 12'h004, 32'h05);
    repeat (6) @(posedge pclk);
    rd(12'h004, 32'h05);
    apb(1'b1, 12'h004, 32'h08);
    apb(1'b1, 12'h004, 32'h00);
    rd(12'h004, 32'h0d);
    apb(1'b1, 12'h004, 32'h18);
    apb(1'b1, 12'h004, 32'h2a);
    repeat (6) @(posedge pclk);
    rd(12'h004, 32'h0d);
    apb(1'b1, 12'h004, 32'h18);
    apb(1'b1, 12'h004, 32'h00);
    repeat (6) @(posedge pclk);
    rd(12'h004, 32'h00);
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test unlock done");
    apb(1'b1, 12'h004, 32'h40);
    repeat (30) begin
      pulse(1'b0);
      repeat (40) @(posedge pclk);
    end
    chk({31'h0, dog_irq}, 32'h0);
    waitv(1'b1, 1'b1, 400);
    rd(12'h004, 32'hc0);
    apb(1'b1, 12'h004, 32'hc0);
    waitv(1'b1, 1'b0, 5);
    apb(1'b1, 12'h004, 32'h48);
    waitv(1'b1, 1'b1, 400);
    chk({31'h0, core_reset_n}, 32'h1);
    pulse(1'b1);
    repeat (3) @(posedge pclk);
    rd(12'h004, 32'h08);
    waitv(1'b0, 1'b0, 400);
    cm = 8;
    waitv(1'b0, 1'b1, 300);
    dog_off();
    dog_always_on_fuse <= 1'b1;
    apb(1'b1, 12'h004, 32'h40);
    repeat (6) @(posedge pclk);
    rd(12'h004, 32'h08);
    waitv(1'b0, 1'b0, 400);
    dog_always_on_fuse <= 1'b0;
    cm = 8;
    waitv(1'b0, 1'b1, 300);
    dog_off();
    $display("test dog done");
    src(1'b0, 300);
    waitv(1'b0, 1'b1, 400);
    power_ok_n <= 1'b0;
    repeat (20) @(posedge pclk);
    power_ok_n <= 1'b1;
    cm = 1;
    waitv(1'b0, 1'b1, 300);
    rd(12'h000, 32'(cm));
    $display("test power mid-run done");
    close_out();
  end
endmodule // rcw_top_bench

bind rcw_top rcw_top_sva u_rcw_top_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .power_ok_n, .ext_reset_pin_n, .ext_pin_reset_disable_fuse, .supply_drop_low,
  .supply_drop_level_fuse, .startup_delay_period, .dog_vector_taken, .core_reset_n, .dog_irq,
  .supply_drop_enable, .supply_drop_level_sel);
